// File: logic/seq_pkg.sv
// Functional notes
// - all outputs except reg_rdata low while reset held; reg_rdata keeps its last read value
// - reset needed; reset itself never means low power
// - standby entered only after current frame completes
// - standby drives every video and sync output low
// - serial port inactive during standby
// - id register reports filter variant and fixed value
package seq_pkg;

   // register map
   localparam logic [7:0] FILTER_VARIANT_ID_ADDR = 8'h6b;
   localparam int         VARIANT_LSB            = 9;
   localparam int         VARIANT_MSB            = 11;
   localparam logic [8:0] ID_FIXED_DEFAULT       = 9'h0a5;  // arbitrary value

   // colour filter variants
   localparam logic [2:0] VARIANT_BAYER = 3'h6;
   localparam logic [2:0] VARIANT_RED_CLEAR = 3'h5;
   localparam logic [2:0] VARIANT_MONO = 3'h0;

   // clocks after reset release before the serial port opens
   localparam logic [3:0] WAKE_EDGES = 4'ha;

   typedef enum logic [2:0] {
      ST_RESET   = 3'b000,
      ST_WAKE    = 3'b001,
      ST_RUN     = 3'b011,
      ST_DRAIN   = 3'b010,
      ST_STANDBY = 3'b110
   } mode_type;

   // video and sync outputs travelling together
   typedef struct packed {
      logic       frame_win;
      logic       line_win;
      logic [9:0] pixel;
      logic       illuminator_strobe_out;
      logic [1:0] serial_shift_clock_pair;
      logic [1:0] serial_pixel_pair;
   } video_bus_type;

   localparam video_bus_type VIDEO_IDLE = '0;

endpackage : seq_pkg

// File: logic/sync_two_flop.sv
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop
   import seq_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] first_stage;

   // first stage read only by second stage
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         first_stage <= '0;
         sync_out    <= '0;
      end else begin
         first_stage <= async_in;
         sync_out    <= first_stage;
      end
   end

endmodule : sync_two_flop
`default_nettype wire

// File: logic/sensor_reset_standby_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_reset_standby_sequencer
   import seq_pkg::*;
#(
   parameter logic [8:0] ID_FIXED = ID_FIXED_DEFAULT  // arbitrary value
) (
   input  wire logic          sys_clk,
   input  wire logic          srst,
   input  wire logic          reset_pin_n,
   input  wire logic          standby_pin,
   input  wire logic [2:0]    color_filter_layout,
   input  wire logic          frame_active,
   input  wire video_bus_type core_video,
   input  wire logic          reg_rd_en,
   input  wire logic [7:0]    reg_addr,
   output video_bus_type      video_out,
   output logic               serial_enable,
   output logic               frame_start_allow,
   output logic               low_power,
   output logic               reg_hit,
   output logic [11:0]        reg_rdata
);

   typedef struct packed {
      mode_type      mode;
      logic [3:0]    wake_cnt;
      logic [2:0]    variant;
      video_bus_type video;
      logic          serial_en;
      logic          start_allow;
      logic          low_power;
      logic          hit;
      logic [11:0]   rdata;
      logic [3:0]    up_cnt;  // cycles since reset release, for checks
   } state_type;

   state_type  st;
   state_type  next_st;
   logic       rst_n_s;
   logic       standby_s;
   logic [2:0] layout_s;

   // pins from the host pass two flops
   sync_two_flop #(.WIDTH(2)) u_pin_sync (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .async_in ({reset_pin_n, standby_pin}),
      .sync_out ({rst_n_s, standby_s})
   );

   // variant strap is a pin as well
   sync_two_flop #(.WIDTH(3)) u_strap_sync (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .async_in (color_filter_layout),
      .sync_out (layout_s)
   );

   // modes in which the readout path may drive outputs
   function automatic logic video_live(input mode_type m);
      video_live = (m == ST_RUN) || (m == ST_DRAIN);
   endfunction : video_live

   // mode sequencing and registered outputs
   always_comb begin
      next_st = st;
      next_st.hit = 1'b0;
      if (!rst_n_s) begin
         next_st.mode     = ST_RESET;
         next_st.wake_cnt = '0;
         next_st.variant  = layout_s;  // strap caught while held
      end else begin
         case (st.mode)
            ST_RESET: begin
               next_st.mode     = ST_WAKE;
               next_st.wake_cnt = '0;
            end
            ST_WAKE: begin
               next_st.wake_cnt = st.wake_cnt + 4'h1;
               if (st.wake_cnt == WAKE_EDGES - 4'h1) begin
                  next_st.mode = ST_RUN;
               end
            end
            ST_RUN: begin
               if (standby_s) begin
                  next_st.mode = ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (!standby_s) begin
                  next_st.mode = ST_RUN;
               end else if (!frame_active) begin
                  next_st.mode = ST_STANDBY;
               end
            end
            ST_STANDBY: begin
               if (!standby_s) begin
                  next_st.mode = ST_RUN;
               end
            end
            default: begin
               next_st.mode = ST_RESET;
            end
         endcase
      end
      // cycles with the reset pin released, saturating; read by checks only
      if (!rst_n_s) begin
         next_st.up_cnt = '0;
      end else if (st.up_cnt != '1) begin
         next_st.up_cnt = st.up_cnt + 4'h1;
      end
      next_st.video       = video_live(next_st.mode) ? core_video : VIDEO_IDLE;
      next_st.start_allow = (next_st.mode == ST_RUN);
      // serial port only in live modes
      next_st.serial_en   = video_live(next_st.mode);
      next_st.low_power   = (next_st.mode == ST_STANDBY);
      if (st.serial_en && reg_rd_en && reg_addr == FILTER_VARIANT_ID_ADDR) begin
         next_st.hit   = 1'b1;
         next_st.rdata = {st.variant, ID_FIXED};
      end
   end

   // single state register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st      <= '0;
         st.mode <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign video_out         = st.video;
   assign serial_enable     = st.serial_en;
   assign frame_start_allow = st.start_allow;
   assign low_power         = st.low_power;
   assign reg_hit           = st.hit;
   assign reg_rdata         = st.rdata;

   // checks on reset and standby behaviour
   a_reset_outputs_low: assert property (
      @(posedge sys_clk) disable iff (srst)
      !rst_n_s |=> (video_out == VIDEO_IDLE) && !serial_enable)
      else $error("outputs not low while reset held");

   a_reset_not_lowpower: assert property (
      @(posedge sys_clk) disable iff (srst)
      !rst_n_s |=> !low_power)
      else $error("reset entered low power");

   a_wake_port_closed: assert property (
      @(posedge sys_clk) disable iff (srst)
      $rose(serial_enable) |-> (st.up_cnt >= WAKE_EDGES))
      else $error("serial port opened too early");

   a_wake_port_opens: assert property (
      @(posedge sys_clk) disable iff (srst)
      ($rose(rst_n_s) && !standby_s) ##1 (rst_n_s && !standby_s) [*8]
      |-> ##[3:4] serial_enable)
      else $error("serial port not opened after wake");

   a_drain_holds_frame: assert property (
      @(posedge sys_clk) disable iff (srst)
      (st.mode == ST_DRAIN && frame_active && rst_n_s) |=> !low_power)
      else $error("standby entered mid frame");

   a_standby_outputs_low: assert property (
      @(posedge sys_clk) disable iff (srst)
      low_power |-> (video_out == VIDEO_IDLE) && !frame_start_allow)
      else $error("video active in standby");

   a_standby_port_off: assert property (
      @(posedge sys_clk) disable iff (srst)
      low_power |=> !reg_hit)
      else $error("serial port answered in standby");

   a_id_field_value: assert property (
      @(posedge sys_clk) disable iff (srst)
      reg_hit |-> (reg_rdata[VARIANT_MSB:VARIANT_LSB] == st.variant)
                  && (reg_rdata[VARIANT_LSB-1:0] == ID_FIXED))
      else $error("id register value wrong");

   a_standby_resume: assert property (
      @(posedge sys_clk) disable iff (srst)
      (low_power && rst_n_s && !standby_s) |=> serial_enable && frame_start_allow)
      else $error("no resume after standby");

   a_hit_needs_port: assert property (
      @(posedge sys_clk) disable iff (srst)
      reg_hit |-> $past(serial_enable))
      else $error("read answered with port closed");

   a_other_addr_quiet: assert property (
      @(posedge sys_clk) disable iff (srst)
      (reg_rd_en && reg_addr != FILTER_VARIANT_ID_ADDR) |=> !reg_hit)
      else $error("read of other address answered");

   a_rdata_held: assert property (
      @(posedge sys_clk) disable iff (srst)
      !reg_hit |-> $stable(reg_rdata))
      else $error("read data changed without a read");

   a_drain_no_start: assert property (
      @(posedge sys_clk) disable iff (srst)
      (st.mode == ST_DRAIN) |-> !frame_start_allow)
      else $error("new frame allowed while draining");

   a_standby_after_frame: assert property (
      @(posedge sys_clk) disable iff (srst)
      $rose(low_power) |-> !$past(frame_active) && $past(standby_s))
      else $error("standby entered before frame end");

endmodule : sensor_reset_standby_sequencer
`default_nettype wire

// File: verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic sys_clk,
   output logic      reset_pin_n,
   output logic      standby_pin
);
   // pins start with reset asserted
   initial begin
      reset_pin_n = 1'b0;
      standby_pin = 1'b0;
   end
   task automatic hold_reset();
      reset_pin_n <= 1'b0;
   endtask : hold_reset
   task automatic release_reset();
      repeat (150) @(posedge sys_clk);
      reset_pin_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
   endtask : release_reset
   task automatic set_standby(input logic v);
      standby_pin <= v;
   endtask : set_standby
endmodule : host_model
`default_nettype wire

// File: verif/test_sensor_reset_standby_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_sensor_reset_standby_sequencer
   import seq_pkg::*;
;
   logic          sys_clk = 1'b0;
   logic          srst = 1'b1;
   logic          frame_active = 1'b0;
   logic          reg_rd_en = 1'b0;
   logic [7:0]    reg_addr = 8'h00;
   logic [2:0]    color_filter_layout = 3'h0;
   video_bus_type core_video = 17'h1a5a5;
   video_bus_type video_out;
   logic          reset_pin_n, standby_pin, serial_enable, frame_start_allow, low_power, reg_hit;
   logic [11:0]   reg_rdata;
   int            fail_count = 0;
   int            tests_run = 0;
   // clock and parts
   initial forever #2.5 sys_clk = ~sys_clk;
   host_model i_host_model (.sys_clk(sys_clk), .reset_pin_n(reset_pin_n),
      .standby_pin(standby_pin));
   sensor_reset_standby_sequencer i_sensor_reset_standby_sequencer (
      .sys_clk(sys_clk), .srst(srst), .reset_pin_n(reset_pin_n), .standby_pin(standby_pin),
      .color_filter_layout(color_filter_layout), .frame_active(frame_active),
      .core_video(core_video), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .video_out(video_out), .serial_enable(serial_enable),
      .frame_start_allow(frame_start_allow), .low_power(low_power), .reg_hit(reg_hit),
      .reg_rdata(reg_rdata));
   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one register read; answer judged in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic hit, input logic [11:0] exp);
      reg_addr  <= a;
      reg_rd_en <= 1'b1;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      #1;
      check("reg_hit", 17'(reg_hit), 17'(hit));
      if (hit) check("reg_rdata", 17'(reg_rdata), 17'(exp));
      @(posedge sys_clk);
   endtask : rd
   // bounded wait for low_power or serial_enable, returns just after an edge
   task automatic wait_up(input logic lp);
      for (int i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         #1;
         if ((lp ? low_power : serial_enable) === 1'b1) break;
      end
   endtask : wait_up
   // reset hold, strap capture and identification read
   task automatic t_variant(input logic [2:0] v);
      color_filter_layout <= v;
      i_host_model.hold_reset();
      repeat (6) @(posedge sys_clk);
      #1;
      check("video_out", video_out, '0);
      check("serial_enable", 17'(serial_enable), 17'h0);
      check("low_power", 17'(low_power), 17'h0);
      i_host_model.release_reset();
      color_filter_layout <= ~v;
      #1;
      check("serial_enable", 17'(serial_enable), 17'h0);
      wait_up(1'b0);
      check("serial_enable", 17'(serial_enable), 17'h1);
      @(posedge sys_clk);
      rd(8'h6b, 1'b1, {v, ID_FIXED_DEFAULT});
      rd(8'h6a, 1'b0, 12'h000);
   endtask : t_variant
   // standby waits for the frame, blanks outputs, then resumes
   task automatic t_standby();
      frame_active <= 1'b1;
      core_video   <= 17'h1c3c3;
      repeat (3) @(posedge sys_clk);
      i_host_model.set_standby(1'b1);
      repeat (12) @(posedge sys_clk);
      #1;
      check("low_power", 17'(low_power), 17'h0);
      check("frame_start_allow", 17'(frame_start_allow), 17'h0);
      check("video_out", video_out, core_video);
      @(posedge sys_clk);
      frame_active <= 1'b0;
      wait_up(1'b1);
      check("low_power", 17'(low_power), 17'h1);
      check("video_out", video_out, '0);
      check("serial_enable", 17'(serial_enable), 17'h0);
      @(posedge sys_clk);
      rd(8'h6b, 1'b0, 12'h000);
      i_host_model.set_standby(1'b0);
      wait_up(1'b0);
      check("low_power", 17'(low_power), 17'h0);
      check("frame_start_allow", 17'(frame_start_allow), 17'h1);
      check("video_out", video_out, core_video);
      @(posedge sys_clk);
      rd(8'h6b, 1'b1, {VARIANT_MONO, ID_FIXED_DEFAULT});
   endtask : t_standby
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      t_variant(VARIANT_BAYER);
      t_variant(VARIANT_RED_CLEAR);
      t_variant(VARIANT_MONO);
      t_standby();
      end_sim();
   end
   // watchdog far beyond the roughly 550 cycles the run needs
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      end_sim();
   end
endmodule : test_sensor_reset_standby_sequencer
`default_nettype wire
